// ==== tb/slf_top_test.sv ====
// Self-checking bench for the safety logic gates, latches, bypass and delay.
// Assumes slf_top with TICK_DIV 4, so one millisecond is four clocks.
`timescale 1ns/1ps
module slf_top_test
  import slf_pkg::*;
;
  localparam int MS = 4;
  logic        clock_i;
  logic        nrst_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        or_o, nand_o, nor_o, xor_o, and_o, not_o, rs_o, sr_o;
  logic        byp_o, byp_active_o, twohand_stop_o, dly_o;
  int          errors;
  int          total_checks;

  slf_top #(.NIN(MAX_INPUTS), .TICK_DIV(MS)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .or_o(or_o),
    .nand_o(nand_o), .nor_o(nor_o), .xor_o(xor_o), .and_o(and_o),
    .not_o(not_o), .rs_o(rs_o), .sr_o(sr_o), .byp_o(byp_o),
    .byp_active_o(byp_active_o), .twohand_stop_o(twohand_stop_o),
    .dly_o(dly_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic end_sim();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk32(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Three scans: enough for any combinational block result to land
  task automatic settle();
    repeat (3 * MS) @(posedge clock_i);
    #1;
  endtask

  task automatic test_regs();
    logic [31:0] d;
    rd(ADDR_BYP_TIME, d); chk32("byp_time_rst", BYP_TIME_RST, d);
    rd(ADDR_DLY_TIME, d); chk32("dly_time_rst", DLY_TIME_RST, d);
    rd(ADDR_SCAN, d); chk32("scan_rst", 32'h00000001, d);
    rd(4'h8, d); chk32("unmapped", 32'h00000000, d);
    wr(ADDR_BYP_TIME, 32'h00000005);
    rd(ADDR_BYP_TIME, d); chk32("byp_min", 32'h000003E8, d);
    wr(ADDR_BYP_TIME, 32'h0FFFFFFF);
    rd(ADDR_BYP_TIME, d); chk32("byp_max", 32'h02932E00, d);
    wr(ADDR_DLY_TIME, 32'h00000000);
    rd(ADDR_DLY_TIME, d); chk32("dly_min", 32'h00000001, d);
    wr(ADDR_DLY_TIME, 32'h00061A80);
    rd(ADDR_DLY_TIME, d); chk32("dly_max", 32'h000493E0, d);
    wr(ADDR_SCAN, 32'h00000000);
    rd(ADDR_SCAN, d); chk32("scan_zero", 32'h00000001, d);
  endtask

  task automatic test_gates();
    logic [4:0]  pat [8] = '{5'h00, 5'h1F, 5'h01, 5'h03, 5'h10, 5'h0A,
                             5'h1C, 5'h02};
    logic [4:0]  m;
    logic [2:0]  n;
    logic        inv;
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      n   = (i < 6) ? 3'h5 : 3'h2;
      inv = i[0];
      m   = pat[i] & ((5'h01 << n) - 5'h01);
      wr(ADDR_GATE_IN, {15'h0000, inv, 5'h00, n, 3'h0, pat[i]});
      settle();
      chk1("or", |m, or_o);
      chk1("nand", ~&(m | ~((5'h01 << n) - 5'h01)), nand_o);
      chk1("nor", ~|m, nor_o);
      chk1("xor", $countones(m) == 1, xor_o);
      chk1("and", &(m | ~((5'h01 << n) - 5'h01)), and_o);
      chk1("not", ~inv, not_o);
    end
    rd(ADDR_STATUS, d);
    chk32("status_gates", 32'h000000D0, {24'h000000, d[7:0]});
  endtask

  task automatic test_latches();
    logic [3:0] v  [7] = '{4'h5, 4'h0, 4'hF, 4'h0, 4'hA, 4'h1, 4'h4};
    logic       er [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic       es [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_LATCH_IN, {28'h0000000, v[i]});
      settle();
      chk1("rs", er[i], rs_o);
      chk1("sr", es[i], sr_o);
    end
  endtask

  task automatic test_bypass();
    int c;
    wr(ADDR_BYP_TIME, 32'h000003E8);
    wr(ADDR_BYP_CTL, 32'h00000001); settle();
    chk1("byp_pass1", 1'b1, byp_o);
    wr(ADDR_BYP_CTL, 32'h00000000); settle();
    chk1("byp_pass0", 1'b0, byp_o);
    wr(ADDR_BYP_CTL, 32'h00000002); settle();
    chk1("byp_force", 1'b1, byp_o);
    wr(ADDR_BYP_CTL, 32'h00000007); settle();
    chk1("byp_both_off", 1'b0, byp_o);
    wr(ADDR_BYP_CTL, 32'h0000001A); settle();
    chk1("twohand_stop", 1'b1, twohand_stop_o);
    wr(ADDR_BYP_CTL, 32'h00000000); settle();
    // A fresh request restarts the one shared limit
    wr(ADDR_BYP_CTL, 32'h00000002);
    c = 0;
    while (byp_active_o !== 1'b1) begin
      @(posedge clock_i);
      #1;
      c++;
      if (c == 1000 * MS - 3 * MS) begin
        chk1("byp_held", 1'b1, byp_o);
      end
      if (c > 1000 * MS + 3 * MS) begin
        chk1("byp_expiry", 1'b1, byp_active_o);
        break;
      end
    end
    chk1("byp_early", 1'b1, c >= 1000 * MS - MS);
    settle();
    chk1("byp_off", 1'b0, byp_o);
    wr(ADDR_BYP_CTL, 32'h00000000);
  endtask

  task automatic test_delay();
    wr(ADDR_DLY_TIME, 32'h0000000A);
    wr(ADDR_DLY_CTL, 32'h00000001); settle();
    chk1("dly_none", 1'b1, dly_o);
    wr(ADDR_DLY_CTL, 32'h00000004); settle();
    wr(ADDR_DLY_CTL, 32'h00000005);
    repeat (8 * MS) @(posedge clock_i);
    #1;
    chk1("on_dly_hold", 1'b0, dly_o);
    repeat (5 * MS) @(posedge clock_i);
    #1;
    chk1("on_dly_done", 1'b1, dly_o);
    wr(ADDR_DLY_CTL, 32'h00000003); settle();
    chk1("off_dly_rise", 1'b1, dly_o);
    wr(ADDR_DLY_CTL, 32'h00000002);
    repeat (8 * MS) @(posedge clock_i);
    #1;
    chk1("off_dly_hold", 1'b1, dly_o);
    repeat (5 * MS) @(posedge clock_i);
    #1;
    chk1("off_dly_done", 1'b0, dly_o);
    wr(ADDR_DLY_CTL, 32'h00000003); settle();
    wr(ADDR_DLY_CTL, 32'h00000012);
    wr(ADDR_DLY_CTL, 32'h00000052); settle();
    chk1("cancel_off", 1'b0, dly_o);
    // Node cancel with keep-on must outlast the full delay
    wr(ADDR_DLY_CTL, 32'h00000003); settle();
    wr(ADDR_DLY_CTL, 32'h00000032);
    wr(ADDR_DLY_CTL, 32'h00000072); settle();
    chk1("cancel_keep", 1'b1, dly_o);
    repeat (12 * MS) @(posedge clock_i);
    #1;
    chk1("keep_stays", 1'b1, dly_o);
    wr(ADDR_DLY_CTL, 32'h0000000B); settle();
    wr(ADDR_DLY_CTL, 32'h0000000A);
    wr(ADDR_DLY_CTL, 32'h0000004A); settle();
    chk1("cancel_ctrl", 1'b0, dly_o);
  endtask

  initial begin
    errors       = 0;
    total_checks = 0;
    nrst_i       = 1'b0;
    addr_i       = 4'h0;
    wdata_i      = 32'h00000000;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    repeat (19) @(posedge clock_i);
    #1;
    chk1("rst_dly", 1'b0, dly_o);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    test_regs();
    test_gates();
    test_latches();
    test_bypass();
    test_delay();
    end_sim();
  end
endmodule

// ==== verilog/slf_delay.sv ====
// On/off delay with millisecond counting and cancel options.
// Assumes tick_i is a one-cycle pulse once per millisecond.
`timescale 1ns/1ps
module slf_delay
  import slf_pkg::*;
#(
  parameter int unsigned CW = 19
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             tick_i,
  input  wire logic             scan_i,
  input  wire slf_dly_cfg_type  cfg_i,
  input  wire logic [CW-1:0]    time_i,
  output logic                  out_o,
  output logic                  busy_o
);
  logic [CW-1:0] cnt_reg;
  logic          out_reg;
  logic          run_reg;
  logic          in_reg;
  logic          cancel_hit;

  default clocking main_cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  assign out_o  = out_reg;
  assign busy_o = run_reg;

  // Cancel only exists in off-delay mode
  always_comb begin
    cancel_hit = 1'b0;
    if (cfg_i.mode == DLY_OFF) begin
      if (cfg_i.cancel == CAN_NODE) begin
        cancel_hit = cfg_i.cancel_node;
      end else if (cfg_i.cancel == CAN_CTRL) begin
        cancel_hit = cfg_i.ctrl_input;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_reg  <= 1'b0;
      out_reg <= 1'b0;
      run_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      if (tick_i && run_reg && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
      if (scan_i) begin
        in_reg <= cfg_i.in_state;
        case (cfg_i.mode)
          DLY_NONE: begin
            out_reg <= cfg_i.in_state;
            run_reg <= 1'b0;
          end
          DLY_ON: begin
            // Output stays Off until the delay has run out
            if (!cfg_i.in_state) begin
              out_reg <= 1'b0;
              run_reg <= 1'b0;
            end else if (!in_reg) begin
              run_reg <= 1'b1;
              cnt_reg <= time_i;
            end else if (run_reg && cnt_reg == '0) begin
              out_reg <= 1'b1;
              run_reg <= 1'b0;
            end
          end
          default: begin
            if (cfg_i.in_state) begin
              out_reg <= 1'b1;
              run_reg <= 1'b0;
            end else if (in_reg) begin
              run_reg <= 1'b1;
              cnt_reg <= time_i;
            end else if (run_reg && cancel_hit) begin
              // Node cancel may keep the output On
              out_reg <= (cfg_i.cancel == CAN_NODE)
                         ? cfg_i.end_keep_on : 1'b0;
              run_reg <= 1'b0;
            end else if (run_reg && cnt_reg == '0) begin
              out_reg <= 1'b0;
              run_reg <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  on_delay_a: assert property (
    (scan_i && cfg_i.mode == DLY_ON && !cfg_i.in_state) |=> !out_reg)
    else $error("on delay output not off");
  none_mode_a: assert property (
    (scan_i && cfg_i.mode == DLY_NONE) |=> out_reg == $past(cfg_i.in_state))
    else $error("no-delay output mismatch");
  // Scans coincide with ticks, so only an input edge in a delay mode is left out here
  cnt_down_a: assert property (
    (tick_i && run_reg && cnt_reg != '0
     && !(scan_i && cfg_i.mode != DLY_NONE && cfg_i.in_state != in_reg))
    |=> cnt_reg == $past(cnt_reg) - CW'(1))
    else $error("delay counter did not step");
  dly_on_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
    cfg_i.mode == DLY_ON && $rose(out_reg));
  dly_off_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
    cfg_i.mode == DLY_OFF && $fell(out_reg));
endmodule

// ==== verilog/slf_pkg.sv ====
// Shared constants and types for the safety logic function blocks.
// Assumes a 40 MHz system clock and a plain register port.
package slf_pkg;
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MAX_INPUTS   = 5;
  localparam int unsigned MIN_INPUTS   = 2;
  localparam int unsigned BYP_MIN_S    = 1;
  localparam int unsigned BYP_MAX_S    = 43200;
  localparam int unsigned BYP_MIN_MS   = BYP_MIN_S * 1000;
  localparam int unsigned BYP_MAX_MS   = BYP_MAX_S * 1000;
  localparam int unsigned DLY_MIN_MS   = 1;
  localparam int unsigned DLY_MAX_MS   = 300000;
  localparam int unsigned DLY_DEF_MS   = 100;
  localparam int unsigned SCAN_MS      = 1;

  localparam logic [3:0] ADDR_GATE_IN  = 4'h0;
  localparam logic [3:0] ADDR_LATCH_IN = 4'h1;
  localparam logic [3:0] ADDR_BYP_CTL  = 4'h2;
  localparam logic [3:0] ADDR_BYP_TIME = 4'h3;
  localparam logic [3:0] ADDR_DLY_CTL  = 4'h4;
  localparam logic [3:0] ADDR_DLY_TIME = 4'h5;
  localparam logic [3:0] ADDR_STATUS   = 4'h6;
  localparam logic [3:0] ADDR_SCAN     = 4'h7;

  localparam logic [2:0] GATE_CNT_RST  = 3'h5;
  localparam logic [31:0] BYP_TIME_RST = 32'h000003E8;
  localparam logic [31:0] DLY_TIME_RST = 32'h00000064;
  localparam logic [15:0] SCAN_RST     = 16'h0001;

  typedef enum logic [1:0] {
    DLY_NONE, DLY_OFF, DLY_ON
  } slf_dly_mode_type;

  typedef enum logic [1:0] {
    CAN_NONE, CAN_CTRL, CAN_NODE
  } slf_cancel_type;

  typedef struct packed {
    logic or_q;
    logic nand_q;
    logic nor_q;
    logic xor_q;
    logic and_q;
    logic not_q;
    logic rs_q;
    logic sr_q;
  } slf_logic_out_type;

  typedef struct packed {
    logic             in_state;
    slf_dly_mode_type mode;
    slf_cancel_type   cancel;
    logic             end_keep_on;
    logic             cancel_node;
    logic             ctrl_input;
  } slf_dly_cfg_type;
endpackage

// ==== verilog/slf_top.sv ====
// Safety logic gates, latches, bypass and delay blocks behind a register
// port. Assumes strobes are one cycle and never both high at once.
// Function
// - OR gate on two to five inputs
// - NAND Off only when all inputs On
// - NOR On only when all Off
// - XOR On when exactly one input On
// - Inverter complements its input
// - Reset-priority latch clears when both On
// - Set-priority latch sets when both On
// - Bypass inactive passes safety input through
// - Active bypass forces output On
// - Option: both On forces bypass output Off
// - Bypass timer expiry hands output back to the safety input
// - Bypass limit one second to twelve hours
// - One bypass limit for every input
// - Two-hand actuation under bypass gives Stop
// - Delay one millisecond steps, five minutes max
// - Delay overrun at most one scan
// - Delay mode none/off/on, default 100 ms
// - Cancel selection only in off-delay mode
// - Node cancel end action keeps or clears
// - AND gate On only when all On
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module slf_top
  import slf_pkg::*;
#(
  parameter int unsigned NIN      = MAX_INPUTS,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             or_o,
  output logic             nand_o,
  output logic             nor_o,
  output logic             xor_o,
  output logic             and_o,
  output logic             not_o,
  output logic             rs_o,
  output logic             sr_o,
  output logic             byp_o,
  output logic             byp_active_o,
  output logic             twohand_stop_o,
  output logic             dly_o
);
  logic [NIN-1:0]    gate_in_reg;
  logic [2:0]        gate_cnt_reg;
  logic              not_in_reg;
  logic [3:0]        latch_in_reg;
  logic [4:0]        byp_ctl_reg;
  logic [31:0]       byp_time_reg;
  logic [31:0]       byp_cnt_reg;
  logic              byp_expired_reg;
  logic [6:0]        dly_ctl_reg;
  logic [31:0]       dly_time_reg;
  logic [15:0]       scan_div_reg;
  logic [15:0]       scan_cnt_reg;
  logic [15:0]       tick_cnt_reg;
  logic              tick_reg;
  logic              scan_reg;
  slf_logic_out_type lo_reg;
  slf_logic_out_type lo_next;
  logic              byp_reg;
  logic              byp_next;
  logic              th_stop_reg;
  logic [31:0]       rdata_reg;
  logic [NIN-1:0]    used;
  logic              dly_out;
  logic              dly_busy;
  slf_dly_cfg_type   dly_cfg;

  default clocking main_cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // Fields of the bypass control word
  logic byp_in, byp_req, byp_both_off, byp_twohand, byp_th_act;
  assign byp_in       = byp_ctl_reg[0];
  assign byp_req      = byp_ctl_reg[1];
  assign byp_both_off = byp_ctl_reg[2];
  assign byp_twohand  = byp_ctl_reg[3];
  assign byp_th_act   = byp_ctl_reg[4];

  // Unused gate inputs become neutral per gate, so masked here
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_used
      assign used[gi] = (3'(gi) < gate_cnt_reg);
    end
  endgenerate

  function automatic logic [2:0] count_ones(input logic [NIN-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NIN; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  // Clamp an input count to the two-to-five range
  function automatic logic [2:0] clamp_cnt(input logic [2:0] v);
    logic [2:0] r;
    r = v;
    if (v < 3'(MIN_INPUTS)) begin
      r = 3'(MIN_INPUTS);
    end else if (v > 3'(NIN)) begin
      r = 3'(NIN);
    end
    return r;
  endfunction

  // Register writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_in_reg  <= '0;
      gate_cnt_reg <= GATE_CNT_RST;
      not_in_reg   <= 1'b0;
      latch_in_reg <= 4'h0;
      byp_ctl_reg  <= 5'h00;
      byp_time_reg <= BYP_TIME_RST;
      dly_ctl_reg  <= 7'h00;
      dly_time_reg <= DLY_TIME_RST;
      scan_div_reg <= SCAN_RST;
    end else if (wr_i) begin
      if (addr_i == ADDR_GATE_IN) begin
        gate_in_reg  <= wdata_i[NIN-1:0];
        gate_cnt_reg <= clamp_cnt(wdata_i[10:8]);
        not_in_reg   <= wdata_i[16];
      end else if (addr_i == ADDR_LATCH_IN) begin
        latch_in_reg <= wdata_i[3:0];
      end else if (addr_i == ADDR_BYP_CTL) begin
        byp_ctl_reg <= wdata_i[4:0];
      end else if (addr_i == ADDR_BYP_TIME) begin
        // One limit for every bypassed input, never zero
        if (wdata_i < BYP_MIN_MS) begin
          byp_time_reg <= BYP_MIN_MS;
        end else if (wdata_i > BYP_MAX_MS) begin
          byp_time_reg <= BYP_MAX_MS;
        end else begin
          byp_time_reg <= wdata_i;
        end
      end else if (addr_i == ADDR_DLY_CTL) begin
        dly_ctl_reg <= wdata_i[6:0];
      end else if (addr_i == ADDR_DLY_TIME) begin
        if (wdata_i < DLY_MIN_MS) begin
          dly_time_reg <= DLY_MIN_MS;
        end else if (wdata_i > DLY_MAX_MS) begin
          dly_time_reg <= DLY_MAX_MS;
        end else begin
          dly_time_reg <= wdata_i;
        end
      end else if (addr_i == ADDR_SCAN) begin
        scan_div_reg <= (wdata_i[15:0] == 16'h0000) ? SCAN_RST
                                                    : wdata_i[15:0];
      end
    end
  end

  // Millisecond tick and scan enable
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_reg <= 16'h0000;
      scan_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
      scan_reg     <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      scan_reg <= 1'b0;
      if (tick_cnt_reg == 16'(TICK_DIV - 1)) begin
        tick_cnt_reg <= 16'h0000;
        tick_reg     <= 1'b1;
        if (scan_cnt_reg >= scan_div_reg - 16'h0001) begin
          scan_cnt_reg <= 16'h0000;
          scan_reg     <= 1'b1;
        end else begin
          scan_cnt_reg <= scan_cnt_reg + 16'h0001;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end

  // Gate and latch evaluation
  always_comb begin
    lo_next        = lo_reg;
    lo_next.or_q   = |(gate_in_reg & used);
    lo_next.and_q  = &(gate_in_reg | ~used);
    lo_next.nand_q = ~&(gate_in_reg | ~used);
    lo_next.nor_q  = ~|(gate_in_reg & used);
    lo_next.xor_q  = (count_ones(gate_in_reg & used) == 3'h1);
    lo_next.not_q  = ~not_in_reg;
    // Set/reset pairs: bits 0/1 reset-dominant, bits 2/3 set-dominant
    if (latch_in_reg[1]) begin
      lo_next.rs_q = 1'b0;
    end else if (latch_in_reg[0]) begin
      lo_next.rs_q = 1'b1;
    end
    if (latch_in_reg[2]) begin
      lo_next.sr_q = 1'b1;
    end else if (latch_in_reg[3]) begin
      lo_next.sr_q = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_reg <= '0;
    end else if (scan_reg) begin
      lo_reg <= lo_next;
    end
  end

  // Bypass output
  always_comb begin
    byp_next = byp_in;
    if (byp_req && !byp_expired_reg) begin
      byp_next = 1'b1;
      if (byp_both_off && byp_in) begin
        byp_next = 1'b0;
      end
    end else if (byp_req) begin
      // After expiry control goes back to the bypassed input
      byp_next = byp_in;
    end
  end

  // Bypass timer restarts only when the request is withdrawn
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byp_cnt_reg     <= 32'h00000000;
      byp_expired_reg <= 1'b0;
    end else if (!byp_req) begin
      byp_cnt_reg     <= 32'h00000000;
      byp_expired_reg <= 1'b0;
    end else if (tick_reg && !byp_expired_reg) begin
      if (byp_cnt_reg + 32'h00000001 >= byp_time_reg) begin
        byp_expired_reg <= 1'b1;
      end
      byp_cnt_reg <= byp_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byp_reg     <= 1'b0;
      th_stop_reg <= 1'b0;
    end else if (scan_reg) begin
      byp_reg     <= byp_next;
      // Two-hand actuated while bypassed raises Stop
      th_stop_reg <= byp_twohand && byp_req && !byp_expired_reg
                     && byp_th_act;
    end
  end

  assign dly_cfg.in_state    = dly_ctl_reg[0];
  assign dly_cfg.mode        = slf_dly_mode_type'(dly_ctl_reg[2:1]);
  assign dly_cfg.cancel      = slf_cancel_type'(dly_ctl_reg[4:3]);
  assign dly_cfg.end_keep_on = dly_ctl_reg[5];
  assign dly_cfg.cancel_node = dly_ctl_reg[6];
  assign dly_cfg.ctrl_input  = dly_ctl_reg[6];

  slf_delay #(
    .CW (19)
  ) u_delay (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tick_i  (tick_reg),
    .scan_i  (scan_reg),
    .cfg_i   (dly_cfg),
    .time_i  (dly_time_reg[18:0]),
    .out_o   (dly_out),
    .busy_o  (dly_busy)
  );

  // Read port, unmapped addresses read zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= 32'h00000000;
      if (rd_i) begin
        if (addr_i == ADDR_GATE_IN) begin
          rdata_reg <= {15'h0000, not_in_reg, 5'h00, gate_cnt_reg,
                        3'h0, 5'(gate_in_reg)};
        end else if (addr_i == ADDR_LATCH_IN) begin
          rdata_reg <= {28'h0000000, latch_in_reg};
        end else if (addr_i == ADDR_BYP_CTL) begin
          rdata_reg <= {27'h0000000, byp_ctl_reg};
        end else if (addr_i == ADDR_BYP_TIME) begin
          rdata_reg <= byp_time_reg;
        end else if (addr_i == ADDR_DLY_CTL) begin
          rdata_reg <= {25'h0000000, dly_ctl_reg};
        end else if (addr_i == ADDR_DLY_TIME) begin
          rdata_reg <= dly_time_reg;
        end else if (addr_i == ADDR_STATUS) begin
          rdata_reg <= {19'h00000, dly_busy, dly_out, th_stop_reg,
                        byp_expired_reg, byp_reg, lo_reg};
        end else if (addr_i == ADDR_SCAN) begin
          rdata_reg <= {16'h0000, scan_div_reg};
        end
      end
    end
  end

  assign rdata_o        = rdata_reg;
  assign or_o           = lo_reg.or_q;
  assign nand_o         = lo_reg.nand_q;
  assign nor_o          = lo_reg.nor_q;
  assign xor_o          = lo_reg.xor_q;
  assign and_o          = lo_reg.and_q;
  assign not_o          = lo_reg.not_q;
  assign rs_o           = lo_reg.rs_q;
  assign sr_o           = lo_reg.sr_q;
  assign byp_o          = byp_reg;
  assign byp_active_o   = byp_expired_reg;
  assign twohand_stop_o = th_stop_reg;
  assign dly_o          = dly_out;

  or_gate_a: assert property (scan_reg
    |=> or_o == |$past(gate_in_reg & used))
    else $error("or output wrong");
  // All-zero reset state is not a valid nand result, so judge per scan
  nand_gate_a: assert property (scan_reg
    |=> nand_o == ~&$past(gate_in_reg | ~used))
    else $error("nand output wrong");
  nor_gate_a: assert property (scan_reg
    |=> nor_o == ~|$past(gate_in_reg & used))
    else $error("nor output wrong");
  xor_gate_a: assert property (xor_o |-> or_o)
    else $error("xor on with no input on");
  not_gate_a: assert property (scan_reg
    |=> not_o != $past(not_in_reg))
    else $error("inverter wrong");
  rs_latch_a: assert property ((scan_reg && latch_in_reg[1])
    |=> !rs_o)
    else $error("reset-dominant latch not cleared");
  sr_latch_a: assert property ((scan_reg && latch_in_reg[2])
    |=> sr_o)
    else $error("set-dominant latch not set");
  byp_pass_a: assert property ((scan_reg && !byp_req)
    |=> byp_o == $past(byp_in))
    else $error("bypass did not pass input");
  byp_force_a: assert property (
    (scan_reg && byp_req && !byp_expired_reg && !byp_both_off)
    |=> byp_o)
    else $error("bypass did not force on");
  byp_limit_a: assert property (
    byp_time_reg >= BYP_MIN_MS && byp_time_reg <= BYP_MAX_MS)
    else $error("bypass limit out of range");
  byp_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(byp_expired_reg));
  th_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(twohand_stop_o));
endmodule
